// >>> upper_window_pkg.sv
/*
  Offsets, widths, reset values and address-forming constants for the
  bridge upper window registers.
  Assumes a configuration port with byte addresses and dword data.
*/
package upper_window_pkg;

  // Register offsets in configuration space
  localparam logic [7:0] OFS_PREFETCH_BASE_HIGH  = 8'h28;
  localparam logic [7:0] OFS_PREFETCH_LIMIT_HIGH = 8'h2C;
  localparam logic [7:0] OFS_IO_BASE_HIGH        = 8'h30;
  localparam logic [7:0] OFS_IO_LIMIT_HIGH       = 8'h32;
  // Dword holding both I/O upper halves
  localparam logic [7:0] OFS_IO_DWORD            = 8'h30;

  // Reset values
  localparam logic [31:0] RST_PREFETCH_HIGH = 32'h0000_0000;
  localparam logic [15:0] RST_IO_HIGH       = 16'h0000;

  // Low address bits implied by a window bound
  localparam int          LOW_BITS      = 20;
  localparam int          IO_FIELD_BITS = 12;
  localparam logic [19:0] LOW_FILL_BASE  = 20'h00000;
  localparam logic [19:0] LOW_FILL_LIMIT = 20'hFFFFF;

  // Byte lane of the I/O limit half in the dword
  localparam int IO_LIMIT_LANE = 2;

endpackage : upper_window_pkg

// >>> window_bus_if.sv
/*
  Carrier of the assembled window bounds between the register bank and
  the forwarding compare.
  Assumes both sides run on one clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface window_bus_if;
  logic [63:0] prefetch_lo;   // Assembled prefetchable base
  logic [63:0] prefetch_hi;   // Assembled prefetchable limit
  logic [31:0] io_lo;         // Assembled I/O base
  logic [31:0] io_hi;         // Assembled I/O limit

  // Register bank drives the bounds
  modport bank (output prefetch_lo, output prefetch_hi, output io_lo, output io_hi);
  // Compare logic reads them
  modport cmp  (input prefetch_lo, input prefetch_hi, input io_lo, input io_hi);
endinterface : window_bus_if
`default_nettype wire

// >>> window_compare.sv
/*
  Inclusive range compare of a request address against the window bounds.
  Assumes bounds and request from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module window_compare
  import upper_window_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Window bounds
  window_bus_if.cmp        win,
  // Request
  input  wire logic        req_valid,
  input  wire logic        req_is_io,
  input  wire logic [63:0] req_addr,
  // Decision
  output logic             fwd_valid,
  output logic             fwd_hit
);

  logic next_fwd_valid;  // Decision pending
  logic next_fwd_hit;    // Decision value

  // Inclusive compare on the matching window
  always_comb begin
    next_fwd_valid = req_valid;
    if (req_is_io) begin
      // Upper address half must be zero for I/O
      next_fwd_hit = (req_addr[63:32] == 32'h0000_0000) &&
                     (req_addr[31:0] >= win.io_lo) &&
                     (req_addr[31:0] <= win.io_hi); // R10 R13
    end else begin
      next_fwd_hit = (req_addr >= win.prefetch_lo) &&
                     (req_addr <= win.prefetch_hi); // R2 R4 R13
    end
    if (!req_valid) begin
      next_fwd_hit = 1'b0;
    end
  end

  // Register the decision
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fwd_valid <= 1'b0;
      fwd_hit   <= 1'b0;
    end else begin
      fwd_valid <= next_fwd_valid;
      fwd_hit   <= next_fwd_hit;
    end
  end

endmodule : window_compare
`default_nettype wire

// >>> bridge_upper_window_regs.sv
/*
  Upper-half window registers of a bridge configuration header and the
  downstream forwarding decision they steer.
  Assumes a single-cycle dword configuration port with byte enables and
  the lower-half bound fields supplied by neighbouring header logic.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1 - Prefetch base high at 28h, RW, reset 0
// R2 - Base high gives prefetch base bits 63:32
// R3 - Prefetch limit high at 2Ch, RW, reset 0
// R4 - Limit high gives prefetch limit bits 63:32
// R5 - I/O base high at 30h, RW, 16 bits
// R6 - I/O base low 20 bits are zero
// R7 - I/O limit high at 32h, RW, 16 bits
// R8 - I/O limit low 20 bits are ones
// R9 - I/O upper fields map to bits 31:20
// R10 - I/O bounds decide I/O forwarding downstream
// R11 - Low prefetch base gives bits 31:20, zeros below
// R12 - Low prefetch limit gives 31:20, ones below
// R13 - Forward only when inclusively inside window
module bridge_upper_window_regs
  import upper_window_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration port
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_hit,
  // Lower-half bound fields from the header
  input  wire logic [11:0] prefetch_window_low_bound,
  input  wire logic [11:0] prefetch_window_high_bound,
  // Request to decide on
  input  wire logic        req_valid,
  input  wire logic        req_is_io,
  input  wire logic [63:0] req_addr,
  // Forwarding decision
  output logic             fwd_valid,
  output logic             fwd_hit,
  // Assembled bounds for observation
  output logic [63:0]      prefetch_base_addr,
  output logic [63:0]      prefetch_limit_addr,
  output logic [31:0]      io_base_addr,
  output logic [31:0]      io_limit_addr
);

  logic [31:0] prefetch_base_high;        // Upper base of prefetch window
  logic [31:0] prefetch_limit_high;       // Upper limit of prefetch window
  logic [15:0] io_window_base_high;       // Upper I/O base field
  logic [15:0] io_window_limit_high;      // Upper I/O limit field
  logic [31:0] next_prefetch_base_high;   // Next base high
  logic [31:0] next_prefetch_limit_high;  // Next limit high
  logic [15:0] next_io_window_base_high;  // Next I/O base
  logic [15:0] next_io_window_limit_high; // Next I/O limit
  logic [31:0] next_cfg_rdata;            // Next read data
  logic        next_cfg_hit;              // Next claim flag
  logic [11:0] io_window_low_bound;       // I/O base bits 31:20
  logic [11:0] io_window_high_bound;      // I/O limit bits 31:20

  window_bus_if win ();

  // Byte-lane merge of a dword write
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // Register writes
  always_comb begin
    next_prefetch_base_high   = prefetch_base_high;
    next_prefetch_limit_high  = prefetch_limit_high;
    next_io_window_base_high  = io_window_base_high;
    next_io_window_limit_high = io_window_limit_high;
    if (cfg_wr) begin
      case (cfg_addr)
        // Prefetch base high
        OFS_PREFETCH_BASE_HIGH: begin
          next_prefetch_base_high = merge(prefetch_base_high, cfg_wdata, cfg_be); // R1
        end
        // Prefetch limit high
        OFS_PREFETCH_LIMIT_HIGH: begin
          next_prefetch_limit_high = merge(prefetch_limit_high, cfg_wdata, cfg_be); // R3
        end
        // I/O base in low half, limit in high half
        OFS_IO_DWORD: begin
          {next_io_window_limit_high, next_io_window_base_high} =
            merge({io_window_limit_high, io_window_base_high}, cfg_wdata, cfg_be); // R5 R7
        end
        // I/O limit addressed alone
        OFS_IO_LIMIT_HIGH: begin
          {next_io_window_limit_high, next_io_window_base_high} =
            merge({io_window_limit_high, io_window_base_high},
                  {cfg_wdata[15:0], 16'h0000},
                  {cfg_be[1:0], 2'b00}); // R7
        end
        // Other offsets belong elsewhere
        default: begin
          next_prefetch_base_high = prefetch_base_high;
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prefetch_base_high   <= RST_PREFETCH_HIGH; // R1
      prefetch_limit_high  <= RST_PREFETCH_HIGH; // R3
      io_window_base_high  <= RST_IO_HIGH;       // R5
      io_window_limit_high <= RST_IO_HIGH;       // R7
    end else begin
      prefetch_base_high   <= next_prefetch_base_high;
      prefetch_limit_high  <= next_prefetch_limit_high;
      io_window_base_high  <= next_io_window_base_high;
      io_window_limit_high <= next_io_window_limit_high;
    end
  end

  // Read decode, answered the cycle after the strobe
  always_comb begin
    next_cfg_rdata = 32'h0000_0000;
    next_cfg_hit   = 1'b0;
    if (cfg_rd) begin
      case (cfg_addr)
        // Prefetch base high
        OFS_PREFETCH_BASE_HIGH: begin
          next_cfg_rdata = prefetch_base_high;
          next_cfg_hit   = 1'b1;
        end
        // Prefetch limit high
        OFS_PREFETCH_LIMIT_HIGH: begin
          next_cfg_rdata = prefetch_limit_high;
          next_cfg_hit   = 1'b1;
        end
        // Both I/O halves
        OFS_IO_DWORD: begin
          next_cfg_rdata = {io_window_limit_high, io_window_base_high};
          next_cfg_hit   = 1'b1;
        end
        // I/O limit alone in low half
        OFS_IO_LIMIT_HIGH: begin
          next_cfg_rdata = {16'h0000, io_window_limit_high};
          next_cfg_hit   = 1'b1;
        end
        // Not ours: zero, no claim
        default: begin
          next_cfg_hit = 1'b0;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_hit   <= 1'b0;
    end else begin
      cfg_rdata <= next_cfg_rdata;
      cfg_hit   <= next_cfg_hit;
    end
  end

  // Only the low 12 bits of the 16-bit fields reach bits 31:20
  assign io_window_low_bound  = io_window_base_high[IO_FIELD_BITS-1:0];  // R9
  assign io_window_high_bound = io_window_limit_high[IO_FIELD_BITS-1:0]; // R9

  // Assemble the window bounds
  assign win.prefetch_lo = {prefetch_base_high,
                            prefetch_window_low_bound, LOW_FILL_BASE};   // R2 R11
  assign win.prefetch_hi = {prefetch_limit_high,
                            prefetch_window_high_bound, LOW_FILL_LIMIT}; // R4 R12
  assign win.io_lo       = {io_window_low_bound, LOW_FILL_BASE};         // R6
  assign win.io_hi       = {io_window_high_bound, LOW_FILL_LIMIT};       // R8

  // Bounds out for observation
  assign prefetch_base_addr  = win.prefetch_lo;
  assign prefetch_limit_addr = win.prefetch_hi;
  assign io_base_addr        = win.io_lo;
  assign io_limit_addr       = win.io_hi;

  // Forwarding decision
  window_compare u_cmp (
    .clk       (clk),
    .rst_n     (rst_n),
    .win       (win),
    .req_valid (req_valid),
    .req_is_io (req_is_io),
    .req_addr  (req_addr),
    .fwd_valid (fwd_valid),
    .fwd_hit   (fwd_hit)
  ); // R10 R13

endmodule : bridge_upper_window_regs
`default_nettype wire

// >>> bridge_upper_window_assertions.sv
/*
  Checker for the upper window register bank and its forwarding decision.
  Assumes it is bound to the bank top and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_upper_window_assertions
  import upper_window_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Configuration port
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_hit,
  // Lower-half bounds
  input wire logic [11:0] prefetch_window_low_bound,
  input wire logic [11:0] prefetch_window_high_bound,
  // Request and decision
  input wire logic        req_valid,
  input wire logic        req_is_io,
  input wire logic [63:0] req_addr,
  input wire logic        fwd_valid,
  input wire logic        fwd_hit,
  // Assembled bounds
  input wire logic [63:0] prefetch_base_addr,
  input wire logic [63:0] prefetch_limit_addr,
  input wire logic [31:0] io_base_addr,
  input wire logic [31:0] io_limit_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Offset is one of the four decoded ones
  logic dec;
  assign dec = cfg_addr inside {8'h28, 8'h2C, 8'h30, 8'h32};

  chk_rd_decoded_hit: assert property (cfg_rd && dec |=> cfg_hit)
    else $error("decoded read gave no hit");
  chk_rd_unmapped_zero: assert property (cfg_rd && !dec |=> !cfg_hit && cfg_rdata == 32'h0)
    else $error("unmapped read answered");
  chk_rd_idle_quiet: assert property (!cfg_rd |=> !cfg_hit && cfg_rdata == 32'h0)
    else $error("read data stood without read");
  chk_base_wr_upper: assert property (cfg_wr && cfg_addr == 8'h28 && cfg_be == 4'hF
    |=> prefetch_base_addr[63:32] == $past(cfg_wdata))
    else $error("base high write not seen in bound");
  chk_limit_wr_upper: assert property (cfg_wr && cfg_addr == 8'h2C && cfg_be == 4'hF
    |=> prefetch_limit_addr[63:32] == $past(cfg_wdata))
    else $error("limit high write not seen in bound");
  chk_io_wr_map: assert property (cfg_wr && cfg_addr == 8'h30 && cfg_be == 4'hF
    |=> io_base_addr[31:20] == $past(cfg_wdata[11:0])
    && io_limit_addr[31:20] == $past(cfg_wdata[27:16]))
    else $error("I/O upper fields misplaced");
  chk_prefetch_low_fill: assert property (prefetch_base_addr[31:0] ==
    {prefetch_window_low_bound, 20'h00000} && prefetch_limit_addr[31:0] ==
    {prefetch_window_high_bound, 20'hFFFFF})
    else $error("prefetch low bits wrong");
  chk_io_low_fill: assert property (io_base_addr[19:0] == 20'h00000
    && io_limit_addr[19:0] == 20'hFFFFF)
    else $error("I/O low bits wrong");
  chk_fwd_follows_req: assert property (req_valid |=> fwd_valid)
    else $error("decision missing after request");
  chk_fwd_idle_quiet: assert property (!req_valid |=> !fwd_valid && !fwd_hit)
    else $error("decision without request");
  chk_fwd_mem_range: assert property (req_valid && !req_is_io |=> fwd_hit ==
    ($past(req_addr) >= $past(prefetch_base_addr)
    && $past(req_addr) <= $past(prefetch_limit_addr)))
    else $error("memory forward decision wrong");
  chk_fwd_io_range: assert property (req_valid && req_is_io |=> fwd_hit ==
    ($past(req_addr) >= {32'h0, $past(io_base_addr)}
    && $past(req_addr) <= {32'h0, $past(io_limit_addr)}))
    else $error("I/O forward decision wrong");
endmodule : bridge_upper_window_assertions

bind bridge_upper_window_regs bridge_upper_window_assertions u_chk (.*);
`default_nettype wire

// >>> bridge_upper_window_regs_tb.sv
/*
  Self-checking bench for the upper window register bank.
  Assumes the bank top and package are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none
module bridge_upper_window_regs_tb
  import upper_window_pkg::*;
();
  // Stimulus and observed ports
  logic        clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0;
  logic        req_valid = 0, req_is_io = 0, cfg_hit, fwd_valid, fwd_hit;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, io_base_addr, io_limit_addr;
  logic [11:0] prefetch_window_low_bound = 12'h800;
  logic [11:0] prefetch_window_high_bound = 12'h8FF;
  logic [63:0] req_addr = 64'h0, prefetch_base_addr, prefetch_limit_addr;
  logic [63:0] mb, ml, ib, il;
  int          miscompares = 0, checks_done = 0;

  bridge_upper_window_regs u_dut (.*);

  // 25 MHz clock
  always #20 clk = ~clk;

  // One compare
  task chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // Single-cycle configuration write
  task wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    cfg_wr = 1; cfg_addr = a; cfg_be = b; cfg_wdata = d;
    @(negedge clk);
    cfg_wr = 0;
  endtask : wr

  // Read with expected data and hit
  task rd(input logic [7:0] a, input logic [31:0] e, input logic h);
    @(negedge clk);
    cfg_rd = 1; cfg_addr = a;
    @(negedge clk);
    cfg_rd = 0;
    chk(cfg_rdata, e);
    chk(cfg_hit, h);
  endtask : rd

  // One request and its decision
  task fw(input logic io, input logic [63:0] a, input logic e);
    @(negedge clk);
    req_valid = 1; req_is_io = io; req_addr = a;
    @(negedge clk);
    req_valid = 0;
    chk(fwd_valid, 1'b1);
    chk(fwd_hit, e);
  endtask : fw

  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Watchdog
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end

  // Test sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    rd(OFS_PREFETCH_BASE_HIGH, RST_PREFETCH_HIGH, 1);
    rd(OFS_PREFETCH_LIMIT_HIGH, RST_PREFETCH_HIGH, 1);
    rd(OFS_IO_DWORD, 32'h0, 1);
    $display("test reset values done");
    wr(8'h28, 4'hF, 32'h0000_0001);
    rd(8'h28, 32'h0000_0001, 1);
    wr(8'h2C, 4'hF, 32'hA5C3_0001);
    wr(8'h2C, 4'h6, 32'h0000_0000);
    rd(8'h2C, 32'hA500_0001, 1);
    wr(8'h30, 4'hF, 32'h3012_F010);
    wr(8'h32, 4'h3, 32'h0000_0013);
    rd(8'h30, 32'h0013_F010, 1);
    mb = {32'h1, 12'h800, LOW_FILL_BASE};
    ml = {32'hA500_0001, 12'h8FF, LOW_FILL_LIMIT};
    ib = 64'h0100_0000;
    il = 64'h013F_FFFF;
    chk(prefetch_base_addr, mb);
    chk(prefetch_limit_addr, ml);
    chk(io_base_addr, ib[31:0]);
    chk(io_limit_addr, il[31:0]);
    $display("test register writes done");
    wr(8'h29, 4'hF, 32'hFFFF_FFFF);
    rd(8'h29, 32'h0, 0);
    rd(8'h34, 32'h0, 0);
    rd(8'h28, 32'h0000_0001, 1);
    $display("test unmapped offsets done");
    fw(0, mb - 1, 0);
    fw(0, mb, 1);
    fw(0, ml, 1);
    fw(0, ml + 1, 0);
    fw(1, ib - 1, 0);
    fw(1, ib, 1);
    fw(1, il, 1);
    fw(1, il + 1, 0);
    fw(1, {32'h1, ib[31:0]}, 0);
    // Move the lower-half bound fields and watch the bounds follow
    @(negedge clk);
    prefetch_window_low_bound = 12'h123;
    prefetch_window_high_bound = 12'h456;
    @(negedge clk);
    chk(prefetch_base_addr, {32'h1, 12'h123, LOW_FILL_BASE});
    chk(prefetch_limit_addr, {32'hA500_0001, 12'h456, LOW_FILL_LIMIT});
    fw(0, {32'h1, 12'h122, LOW_FILL_LIMIT}, 0);
    fw(0, {32'h1, 12'h123, LOW_FILL_BASE}, 1);
    $display("test forwarding done");
    // Reset in mid-run clears the upper fields again
    @(negedge clk);
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    rd(8'h28, 32'h0, 1);
    rd(8'h2C, 32'h0, 1);
    rd(8'h30, 32'h0, 1);
    $display("test mid-run reset done");
    end_sim;
  end
endmodule : bridge_upper_window_regs_tb
`default_nettype wire
